/* core/aux_pin_consts.vh */
// constants for the auxiliary pin i/o and clock source register bank
// assumes the control-bus engine hands over a 7-bit page-0 register address
// Notes on behaviour
// - data-line mode: 00 bus, 01 input, 10 output
// - data-line output follows its value bit
// - read bit shows sensed data-line level
// - clock-line mode decodes like data-line mode
// - clock-line output follows its value bit
// - read bit shows sensed clock-line level
// - both lines only pull low, high releases
// - line controls act only in spi mode
// - address straps captured a few edges after reset release, bits 7/6
// - pin three input enable, level readable
// - serial-input bit routes pin three to audio
// - pin two output enable drives value bit
// - second register bits 7..1 need i2c mode
// - codec clock: 0 pll divider, 1 plain divider
// - plain divider input: mclk, gpio two, bclk
// - pll input: mclk, gpio two, bclk
// - pll n: 0->16, 1->17, else code; reset 2
`ifndef AUX_PIN_CONSTS_VH
`define AUX_PIN_CONSTS_VH

// register offsets
`define AUX_OFF_PIN_IO      7'h64
`define AUX_OFF_STRAP_MULTI 7'h65
`define AUX_OFF_CLK_SRC     7'h66

// pin io control register fields
`define AUX_DL_MODE_HI      7
`define AUX_DL_MODE_LO      6
`define AUX_DL_VALUE        5
`define AUX_DL_SENSE        4
`define AUX_CL_MODE_HI      3
`define AUX_CL_MODE_LO      2
`define AUX_CL_VALUE        1
`define AUX_CL_SENSE        0

// strap and multi-pin register fields
`define AUX_STRAP_ADDR0     7
`define AUX_STRAP_ADDR1     6
`define AUX_P3_IN_EN        5
`define AUX_P3_SERIAL_EN    4
`define AUX_P3_SENSE        3
`define AUX_P2_OUT_EN       2
`define AUX_P2_VALUE        1
`define AUX_CODEC_CLK_SEL   0

// clock source register fields
`define AUX_DIV_SRC_HI      7
`define AUX_DIV_SRC_LO      6
`define AUX_PLL_SRC_HI      5
`define AUX_PLL_SRC_LO      4
`define AUX_PLL_N_HI        3
`define AUX_PLL_N_LO        0

// pin mode codes
`define AUX_MODE_BUS        2'h0
`define AUX_MODE_GP_IN      2'h1
`define AUX_MODE_GP_OUT     2'h2

// pll n special codes
`define AUX_PLL_CODE_16     4'h0
`define AUX_PLL_CODE_17     4'h1
`define AUX_PLL_N_16        5'h10
`define AUX_PLL_N_17        5'h11

// reset values
`define AUX_RST_PIN_IO      8'h00
`define AUX_RST_MULTI       5'h00
`define AUX_RST_CLK_SRC     8'h02
`define AUX_RST_PLL_N       5'h02

// edges after reset release before straps are caught
`define AUX_STRAP_WAIT      2'h3

`endif

/* core/aux_sync2.v */
// two-flop synchroniser for a group of pin levels
// assumes each bit is a slow level from a pin, not a bus of related bits
`timescale 1ns/1ps
module aux_sync2 #(
  parameter W = 1
) (
  // clock and reset
  input  wire         i_clk,
  input  wire         i_nrst,
  // pin side and core side
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] stage1; // read only by stage2
  reg [W-1:0] stage2; // safe to use

  // both stages clear together under reset
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;

endmodule

/* core/aux_src_decode.v */
// decodes a 2-bit clock source field into a registered one-hot select
// assumes the clock mux downstream is glitch-safe on select change
`timescale 1ns/1ps
`include "aux_pin_consts.vh"
module aux_src_decode (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_nrst,
  // field in, one-hot out: bit0 mclk, bit1 gpio two, bit2 bclk
  input  wire [1:0] i_code,
  output reg  [2:0] o_sel
);

  reg [2:0] next_sel; // decoded select

  // reserved code selects nothing, so no stray source is routed
  always @* begin
    case (i_code)
      2'h0:    next_sel = 3'h1;
      2'h1:    next_sel = 3'h2;
      2'h2:    next_sel = 3'h4;
      default: next_sel = 3'h0;
    endcase
  end

  // registered so the select never glitches
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sel <= 3'h1;
    end else begin
      o_sel <= next_sel;
    end
  end

endmodule

/* core/aux_pin_io_regs.v */
// auxiliary pin i/o and clock source register bank
// holds the pin io control, strap / multi-pin control and clock
// source registers, and drives the pins and clock selects they steer.
// assumes the control-bus engine (spi or i2c) decodes frames and
// presents one-cycle read and write strobes on the core clock.
// assumes the strap and pin levels arrive straight from the pads, with
// no sync of their own, and that reset is held long enough to settle them
`timescale 1ns/1ps
`include "aux_pin_consts.vh"
module aux_pin_io_regs (
  // clock and reset
  input  wire       I_SYS_CLK,
  input  wire       I_NRST,
  // register port from the control-bus engine
  input  wire [6:0] I_REG_ADDR,
  input  wire       I_REG_WR,
  input  wire [7:0] I_REG_WDATA,
  input  wire       I_REG_RD,
  output wire       O_REG_HIT,
  output reg  [7:0] O_REG_RDATA,
  // interface select strap, 1 spi, 0 i2c
  input  wire       I_IFACE_SELECT,
  // data-line pin, open drain
  input  wire       I_DATA_LINE_IN,
  output reg        O_DATA_LINE_OUT,
  output reg        O_DATA_LINE_OE,
  output reg        O_DATA_LINE_BUS_ROLE,
  // clock-line pin, open drain
  input  wire       I_CLOCK_LINE_IN,
  output reg        O_CLOCK_LINE_OUT,
  output reg        O_CLOCK_LINE_OE,
  output reg        O_CLOCK_LINE_BUS_ROLE,
  // multi-function pins
  input  wire       I_MULTI_PIN_ZERO,
  input  wire       I_MULTI_PIN_ONE,
  input  wire       I_MULTI_PIN_THREE,
  output reg        O_MULTI_PIN_TWO_OUT,
  output reg        O_MULTI_PIN_TWO_OE,
  output reg        O_AUDIO_SERIAL_IN_SEL,
  // clock steering
  output reg        O_CODEC_CORE_CLOCK_SEL,
  output wire [2:0] O_PLAIN_DIVIDER_INPUT_SEL,
  output wire [2:0] O_PLL_INPUT_CLOCK_SEL,
  output reg  [4:0] O_PLL_N
);

  // stored register contents
  // read-only bits keep no written value; they are rebuilt on every read
  reg [7:0] pin_io_ctl;   // data / clock line controls
  reg [4:0] multi_ctl;    // bits 5,4,2,1,0 of second register
  reg [7:0] clk_src;      // clock source and pll n

  // strap capture
  reg [1:0] strap_addr;   // bit1 = address bit 1, bit0 = bit 0
  reg [1:0] strap_wait;   // edges since reset release
  reg       strap_done;   // straps caught once

  // synchronised pin levels
  wire       spi_mode;    // select strap high
  wire       data_line_lvl;
  wire       clock_line_lvl;
  wire       pin_zero_lvl;
  wire       pin_one_lvl;
  wire       pin_three_lvl;

  // decoded modes
  wire [1:0] dl_mode;     // data-line mode field
  wire [1:0] cl_mode;     // clock-line mode field
  wire       dl_gp_in;    // data line acting as input
  wire       dl_gp_out;   // data line acting as output
  wire       cl_gp_in;    // clock line acting as input
  wire       cl_gp_out;   // clock line acting as output
  wire       i2c_mode;    // select strap low

  // address decode
  wire       hit_pin_io;
  wire       hit_multi;
  wire       hit_clk;

  // next values for pin and select flops
  // each one is combinational and loads exactly one output flop
  reg        next_dl_oe;
  reg        next_dl_bus;
  reg        next_cl_oe;
  reg        next_cl_bus;
  reg        next_p2_oe;
  reg        next_p2_out;
  reg        next_serial_sel;
  reg [4:0]  next_pll_n;
  reg [7:0]  next_rdata;

  // interface select strap; it may move while the part runs
  aux_sync2 #(
    .W (1)
  ) u_select_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_IFACE_SELECT),
    .o_sync  (spi_mode)
  );

  // data-line level as seen at the pad
  aux_sync2 #(
    .W (1)
  ) u_data_line_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_DATA_LINE_IN),
    .o_sync  (data_line_lvl)
  );

  // clock-line level as seen at the pad
  aux_sync2 #(
    .W (1)
  ) u_clock_line_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_CLOCK_LINE_IN),
    .o_sync  (clock_line_lvl)
  );

  // pin zero, the strap for address bit 1
  aux_sync2 #(
    .W (1)
  ) u_pin_zero_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_MULTI_PIN_ZERO),
    .o_sync  (pin_zero_lvl)
  );

  // pin one, the strap for address bit 0
  aux_sync2 #(
    .W (1)
  ) u_pin_one_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_MULTI_PIN_ONE),
    .o_sync  (pin_one_lvl)
  );

  // pin three, read as a general purpose input
  aux_sync2 #(
    .W (1)
  ) u_pin_three_sync (
    .i_clk   (I_SYS_CLK),
    .i_nrst  (I_NRST),
    .i_async (I_MULTI_PIN_THREE),
    .o_sync  (pin_three_lvl)
  );

  // the two interface roles are exact opposites
  assign i2c_mode = ~spi_mode;

  // line modes; code 11 is never written by the host, treated as bus
  assign dl_mode = pin_io_ctl[`AUX_DL_MODE_HI:`AUX_DL_MODE_LO];
  assign cl_mode = pin_io_ctl[`AUX_CL_MODE_HI:`AUX_CL_MODE_LO];
  assign dl_gp_in  = spi_mode & (dl_mode == `AUX_MODE_GP_IN);
  assign dl_gp_out = spi_mode & (dl_mode == `AUX_MODE_GP_OUT);
  assign cl_gp_in  = spi_mode & (cl_mode == `AUX_MODE_GP_IN);
  assign cl_gp_out = spi_mode & (cl_mode == `AUX_MODE_GP_OUT);

  // address decode, shared by read and write
  // offsets compare in full, so no register aliases elsewhere
  assign hit_pin_io = (I_REG_ADDR == `AUX_OFF_PIN_IO);
  assign hit_multi  = (I_REG_ADDR == `AUX_OFF_STRAP_MULTI);
  assign hit_clk    = (I_REG_ADDR == `AUX_OFF_CLK_SRC);
  assign O_REG_HIT  = hit_pin_io | hit_multi | hit_clk;

  // register writes; pin io sense bits are stored as zero, other read-only bits are not stored
  // values written in the wrong interface mode are kept
  // a write to an unmapped place falls through every hit and is lost;
  // mode code 11 is stored as written, and the pin logic below then
  // simply leaves that line to the bus engine
  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pin_io_ctl <= `AUX_RST_PIN_IO;
      multi_ctl  <= `AUX_RST_MULTI;
      clk_src    <= `AUX_RST_CLK_SRC;
    end else if (I_REG_WR) begin
      if (hit_pin_io) begin
        // sense bits are read-only and stay zero in storage
        pin_io_ctl <= {I_REG_WDATA[7:5], 1'b0,
                       I_REG_WDATA[3:1], 1'b0};
      end
      if (hit_multi) begin
        multi_ctl <= {I_REG_WDATA[`AUX_P3_IN_EN],
                      I_REG_WDATA[`AUX_P3_SERIAL_EN],
                      I_REG_WDATA[`AUX_P2_OUT_EN],
                      I_REG_WDATA[`AUX_P2_VALUE],
                      I_REG_WDATA[`AUX_CODEC_CLK_SEL]};
      end
      if (hit_clk) begin
        // every bit of this register is read/write
        clk_src <= I_REG_WDATA;
      end
    end
  end

  // strap capture: wait for the synchronisers to fill after release
  // the straps are sampled once, a few edges after release, because the
  // pins only settle through the synchronisers; a strap that moves
  // later is not seen until the next reset
  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      strap_wait <= 2'h0;
      strap_done <= 1'b0;
      strap_addr <= 2'h0;
    end else if (!strap_done) begin
      if (strap_wait == `AUX_STRAP_WAIT) begin
        // pin one is address bit 0, pin zero is bit 1
        strap_addr <= {pin_zero_lvl, pin_one_lvl};
        strap_done <= 1'b1;
      end else begin
        // still counting edges
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // pin drive decisions
  // made from the synced select, so a mode change reaches every pin
  // output in the same cycle and the two interface roles never overlap
  // on the pins
  always @* begin
    // open drain: enable only when pulling low, high releases
    next_dl_oe  = dl_gp_out & ~pin_io_ctl[`AUX_DL_VALUE];
    next_cl_oe  = cl_gp_out & ~pin_io_ctl[`AUX_CL_VALUE];
    // bus engine owns the line unless it is a general purpose pin
    next_dl_bus = ~(dl_gp_in | dl_gp_out);
    next_cl_bus = ~(cl_gp_in | cl_gp_out);
    // pin two is push-pull and only valid in i2c mode
    next_p2_oe  = i2c_mode & multi_ctl[2];
    next_p2_out = i2c_mode & multi_ctl[2] & multi_ctl[1];
    // serial input routing from pin three
    next_serial_sel = i2c_mode & multi_ctl[3];
  end

  // pll n decode: two low codes stand for 16 and 17
  // every other code is its own divider value, which keeps the decode
  // to one small case
  always @* begin
    case (clk_src[`AUX_PLL_N_HI:`AUX_PLL_N_LO])
      `AUX_PLL_CODE_16: next_pll_n = `AUX_PLL_N_16;
      `AUX_PLL_CODE_17: next_pll_n = `AUX_PLL_N_17;
      default: next_pll_n = {1'b0, clk_src[`AUX_PLL_N_HI:`AUX_PLL_N_LO]};
    endcase
  end

  // pin and clock select flops, so outputs never glitch
  // each output sits one flop behind the stored register: a cycle of
  // latency after a write is traded for pads free of decode glitches
  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      // pins released, bus engine owns both lines
      O_DATA_LINE_OUT        <= 1'b0;
      O_DATA_LINE_OE         <= 1'b0;
      O_DATA_LINE_BUS_ROLE   <= 1'b1;
      O_CLOCK_LINE_OUT       <= 1'b0;
      O_CLOCK_LINE_OE        <= 1'b0;
      O_CLOCK_LINE_BUS_ROLE  <= 1'b1;
      O_MULTI_PIN_TWO_OUT    <= 1'b0;
      O_MULTI_PIN_TWO_OE     <= 1'b0;
      O_AUDIO_SERIAL_IN_SEL  <= 1'b0;
      O_CODEC_CORE_CLOCK_SEL <= 1'b0;
      O_PLL_N                <= `AUX_RST_PLL_N;
    end else begin
      // open-drain data is always low; only the enable moves
      O_DATA_LINE_OUT        <= 1'b0;
      O_DATA_LINE_OE         <= next_dl_oe;
      O_DATA_LINE_BUS_ROLE   <= next_dl_bus;
      O_CLOCK_LINE_OUT       <= 1'b0;
      O_CLOCK_LINE_OE        <= next_cl_oe;
      O_CLOCK_LINE_BUS_ROLE  <= next_cl_bus;
      O_MULTI_PIN_TWO_OUT    <= next_p2_out;
      O_MULTI_PIN_TWO_OE     <= next_p2_oe;
      O_AUDIO_SERIAL_IN_SEL  <= next_serial_sel;
      // codec clock source works in both interface modes
      O_CODEC_CORE_CLOCK_SEL <= multi_ctl[0];
      O_PLL_N                <= next_pll_n;
    end
  end

  // both source fields share one decoder shape; each copy adds a flop
  // of its own, so the selects move one edge after the write
  // divider input source select
  aux_src_decode u_div_src (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_code (clk_src[`AUX_DIV_SRC_HI:`AUX_DIV_SRC_LO]),
    .o_sel  (O_PLAIN_DIVIDER_INPUT_SEL)
  );

  // pll input source select
  aux_src_decode u_pll_src (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_code (clk_src[`AUX_PLL_SRC_HI:`AUX_PLL_SRC_LO]),
    .o_sel  (O_PLL_INPUT_CLOCK_SEL)
  );

  // read mux; sense bits read zero unless the pin is an input
  // sense bits come from the synced levels, so a read shows a pin two
  // cycles late; bits not valid in the current interface mode read as
  // zero, while stored control bits read back as written
  always @* begin
    next_rdata = 8'h00;
    if (hit_pin_io) begin
      // stored fields, then the live sense bits on top
      next_rdata = pin_io_ctl;
      next_rdata[`AUX_DL_SENSE] = dl_gp_in & data_line_lvl;
      next_rdata[`AUX_CL_SENSE] = cl_gp_in & clock_line_lvl;
    end else if (hit_multi) begin
      // straps report only in i2c mode
      next_rdata[`AUX_STRAP_ADDR0] = i2c_mode & strap_addr[0];
      next_rdata[`AUX_STRAP_ADDR1] = i2c_mode & strap_addr[1];
      next_rdata[`AUX_P3_IN_EN]      = multi_ctl[4];
      next_rdata[`AUX_P3_SERIAL_EN]  = multi_ctl[3];
      next_rdata[`AUX_P3_SENSE]      =
        i2c_mode & multi_ctl[4] & pin_three_lvl;
      next_rdata[`AUX_P2_OUT_EN]     = multi_ctl[2];
      next_rdata[`AUX_P2_VALUE]      = multi_ctl[1];
      next_rdata[`AUX_CODEC_CLK_SEL] = multi_ctl[0];
    end else if (hit_clk) begin
      // clock source register reads back whole
      next_rdata = clk_src;
    end
  end

  // read data is held until the next read strobe
  // loading only on the strobe keeps the word steady for the bus engine
  // while it shifts the byte out, however long that takes
  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_REG_RDATA <= 8'h00;
    end else if (I_REG_RD) begin
      O_REG_RDATA <= next_rdata;
    end
  end

endmodule

/* tb/aux_line_pullup.sv */
// pin-side model of one open-drain line with its external pull-up
// assumes the block only ever pulls low; a far device may pull low too
`timescale 1ns/1ps
module aux_line_pullup (
  // block side and far side pull-downs
  input  wire logic i_oe,
  input  wire logic i_ext_low,
  // resolved pin level
  output wire logic o_level
);
  // wired-and: any pull-down wins, else the pull-up gives high
  assign o_level = !(i_oe || i_ext_low);
endmodule

/* tb/aux_pin_io_regs_props.sv */
// concurrent checks on the aux pin register bank ports
// assumes one core clock and an active-low asynchronous reset
`timescale 1ns/1ps
module aux_pin_io_regs_props (
  // clock, reset and register port
  input wire logic       I_SYS_CLK,
  input wire logic       I_NRST,
  input wire logic [6:0] I_REG_ADDR,
  input wire logic       I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  // pins and clock steering
  input wire logic       O_DATA_LINE_OUT,
  input wire logic       O_DATA_LINE_OE,
  input wire logic       O_DATA_LINE_BUS_ROLE,
  input wire logic       O_CLOCK_LINE_OUT,
  input wire logic       O_CLOCK_LINE_OE,
  input wire logic       O_CLOCK_LINE_BUS_ROLE,
  input wire logic       O_MULTI_PIN_TWO_OUT,
  input wire logic       O_MULTI_PIN_TWO_OE,
  input wire logic       O_AUDIO_SERIAL_IN_SEL,
  input wire logic       O_CODEC_CORE_CLOCK_SEL,
  input wire logic [2:0] O_PLAIN_DIVIDER_INPUT_SEL,
  input wire logic [2:0] O_PLL_INPUT_CLOCK_SEL,
  input wire logic [4:0] O_PLL_N
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  // source code to one-hot, reserved code selects nothing
  function automatic logic [2:0] oh(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : (3'h1 << c);
  endfunction
  // divider code to n, the two low codes wrap to 16 and 17
  function automatic logic [4:0] pll(input logic [3:0] c);
    return (c == 4'h0) ? 5'h10 : (c == 4'h1) ? 5'h11 : {1'b0, c};
  endfunction
  wire wr65 = I_REG_WR && I_REG_ADDR == 7'h65; // strap/multi write
  wire wr66 = I_REG_WR && I_REG_ADDR == 7'h66; // clock source write
  a_lines_low:
  assert property (!O_DATA_LINE_OUT && !O_CLOCK_LINE_OUT)
    else $error("open-drain line driven high");
  a_pll_n_map:
  assert property (wr66 |=> ##1 O_PLL_N == pll($past(I_REG_WDATA[3:0], 2)))
    else $error("pll n wrong after write");
  a_div_src_sel:
  assert property (wr66 |=> ##1
    O_PLAIN_DIVIDER_INPUT_SEL == oh($past(I_REG_WDATA[7:6], 2)))
    else $error("divider source wrong");
  a_pll_src_sel:
  assert property (wr66 |=> ##1
    O_PLL_INPUT_CLOCK_SEL == oh($past(I_REG_WDATA[5:4], 2)))
    else $error("pll source wrong");
  a_codec_clk_sel:
  assert property (wr65 |=> ##1
    O_CODEC_CORE_CLOCK_SEL == $past(I_REG_WDATA[0], 2))
    else $error("codec clock select wrong");
  a_oe_not_bus:
  assert property (!(O_DATA_LINE_OE && O_DATA_LINE_BUS_ROLE) &&
                   !(O_CLOCK_LINE_OE && O_CLOCK_LINE_BUS_ROLE))
    else $error("line pulled while in bus role");
  a_modes_apart:
  assert property ((O_DATA_LINE_OE || O_CLOCK_LINE_OE) |->
                   !(O_MULTI_PIN_TWO_OE || O_AUDIO_SERIAL_IN_SEL))
    else $error("spi and i2c pin roles both active");
  a_two_out_en:
  assert property (O_MULTI_PIN_TWO_OUT |-> O_MULTI_PIN_TWO_OE)
    else $error("pin two value without enable");
endmodule
bind aux_pin_io_regs aux_pin_io_regs_props u_props (.I_SYS_CLK, .I_NRST,
  .I_REG_ADDR, .I_REG_WR, .I_REG_WDATA, .O_DATA_LINE_OUT, .O_DATA_LINE_OE,
  .O_DATA_LINE_BUS_ROLE, .O_CLOCK_LINE_OUT, .O_CLOCK_LINE_OE,
  .O_CLOCK_LINE_BUS_ROLE, .O_MULTI_PIN_TWO_OUT, .O_MULTI_PIN_TWO_OE,
  .O_AUDIO_SERIAL_IN_SEL, .O_CODEC_CORE_CLOCK_SEL,
  .O_PLAIN_DIVIDER_INPUT_SEL, .O_PLL_INPUT_CLOCK_SEL, .O_PLL_N);

/* tb/aux_pin_io_regs_test.sv */
// self-checking bench for the aux pin and clock source register bank
// assumes the design, pull-up model and checker are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module aux_pin_io_regs_test;
  // design inputs, driven on the rising edge
  logic       I_SYS_CLK = 1'b0;
  logic       I_NRST = 1'b0;
  logic [6:0] I_REG_ADDR = 7'h00;
  logic       I_REG_WR = 1'b0;
  logic [7:0] I_REG_WDATA = 8'h00;
  logic       I_REG_RD = 1'b0;
  logic       I_IFACE_SELECT = 1'b1;   // start in spi mode
  logic       I_MULTI_PIN_ZERO = 1'b0; // address bit one strap
  logic       I_MULTI_PIN_ONE = 1'b1;  // address bit zero strap
  logic       I_MULTI_PIN_THREE = 1'b0;
  logic       d_ext = 1'b0;            // far device pulling data line
  logic       c_ext = 1'b0;            // far device pulling clock line
  // design outputs and resolved pin levels
  wire        I_DATA_LINE_IN, I_CLOCK_LINE_IN;
  logic       O_REG_HIT, O_DATA_LINE_OUT, O_DATA_LINE_OE;
  logic       O_DATA_LINE_BUS_ROLE, O_CLOCK_LINE_OUT, O_CLOCK_LINE_OE;
  logic       O_CLOCK_LINE_BUS_ROLE, O_MULTI_PIN_TWO_OUT;
  logic       O_MULTI_PIN_TWO_OE, O_AUDIO_SERIAL_IN_SEL;
  logic       O_CODEC_CORE_CLOCK_SEL;
  logic [7:0] O_REG_RDATA;
  logic [2:0] O_PLAIN_DIVIDER_INPUT_SEL, O_PLL_INPUT_CLOCK_SEL;
  logic [4:0] O_PLL_N;
  // bookkeeping
  logic [7:0] exp_q[$];                // expected read data, oldest first
  logic [7:0] e, d;
  logic [1:0] m;
  logic       rd_seen = 1'b0;
  int         n_errors = 0, n_tests = 0, i, seed;

  aux_pin_io_regs uut (.I_SYS_CLK, .I_NRST, .I_REG_ADDR, .I_REG_WR,
    .I_REG_WDATA, .I_REG_RD, .O_REG_HIT, .O_REG_RDATA, .I_IFACE_SELECT,
    .I_DATA_LINE_IN, .O_DATA_LINE_OUT, .O_DATA_LINE_OE, .O_DATA_LINE_BUS_ROLE,
    .I_CLOCK_LINE_IN, .O_CLOCK_LINE_OUT, .O_CLOCK_LINE_OE,
    .O_CLOCK_LINE_BUS_ROLE, .I_MULTI_PIN_ZERO, .I_MULTI_PIN_ONE,
    .I_MULTI_PIN_THREE, .O_MULTI_PIN_TWO_OUT, .O_MULTI_PIN_TWO_OE,
    .O_AUDIO_SERIAL_IN_SEL, .O_CODEC_CORE_CLOCK_SEL,
    .O_PLAIN_DIVIDER_INPUT_SEL, .O_PLL_INPUT_CLOCK_SEL, .O_PLL_N);
  aux_line_pullup u_dl (.i_oe(O_DATA_LINE_OE), .i_ext_low(d_ext),
    .o_level(I_DATA_LINE_IN));
  aux_line_pullup u_cl (.i_oe(O_CLOCK_LINE_OE), .i_ext_low(c_ext),
    .o_level(I_CLOCK_LINE_IN));

  always #4 I_SYS_CLK = ~I_SYS_CLK; // 125 MHz

  // read watcher: data stands from the edge after the read edge
  always @(posedge I_SYS_CLK) begin
    rd_seen <= I_REG_RD;
    if (rd_seen) begin
      e = exp_q.pop_front();
      `CHK(O_REG_RDATA, e)
    end
  end

  // one register request, strobe held for exactly one taken edge
  task automatic acc(input logic [6:0] a, input logic w, input logic [7:0] v);
    @(posedge I_SYS_CLK);
    I_REG_ADDR <= a;
    I_REG_WR <= w;
    I_REG_RD <= !w;
    I_REG_WDATA <= v;
    @(posedge I_SYS_CLK);
    I_REG_WR <= 1'b0;
    I_REG_RD <= 1'b0;
  endtask
  // read with its expected value noted for the watcher
  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    acc(a, 1'b0, 8'h00);
  endtask
  // let registered and synced outputs land before sampling
  task automatic wait_n(input int n);
    repeat (n) @(posedge I_SYS_CLK);
    #1;
  endtask
  function automatic logic [2:0] oh(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : (3'h1 << c);
  endfunction
  function automatic logic [4:0] pll(input logic [3:0] c);
    return (c == 4'h0) ? 5'h10 : (c == 4'h1) ? 5'h11 : {1'b0, c};
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end

  initial begin
    seed = 76;
    repeat (4) @(posedge I_SYS_CLK);
    I_NRST <= 1'b1;
    wait_n(8); // straps caught, synced levels valid
    rd(7'h64, 8'h00);
    rd(7'h65, 8'h00);
    rd(7'h66, 8'h02);
    `CHK(O_PLL_N, 5'h02)
    `CHK(O_REG_HIT, 1'b1)
    $display("test reset done");
    // every divider code, every source code incl. reserved
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      d[3:0] = i[3:0];
      d[7:6] = i[1:0];
      d[5:4] = ~i[1:0];
      acc(7'h66, 1'b1, d);
      rd(7'h66, d);
      wait_n(2);
      `CHK(O_PLL_N, pll(d[3:0]))
      `CHK(O_PLAIN_DIVIDER_INPUT_SEL, oh(d[7:6]))
      `CHK(O_PLL_INPUT_CLOCK_SEL, oh(d[5:4]))
    end
    $display("test clock source done");
    // spi mode: bus, input and output modes; sense bits written as 1
    for (i = 0; i < 6; i++) begin
      m = i[2:1]; // runs 0..2, code 11 never sent
      @(posedge I_SYS_CLK);
      d_ext <= $random(seed);
      c_ext <= $random(seed);
      acc(7'h64, 1'b1, {m, i[0], 1'b1, m, !i[0], 1'b1});
      wait_n(4);
      `CHK(O_DATA_LINE_OE, m == 2'h2 && !i[0])
      `CHK(O_CLOCK_LINE_OE, m == 2'h2 && i[0])
      `CHK(O_DATA_LINE_BUS_ROLE, m == 2'h0)
      `CHK(O_CLOCK_LINE_BUS_ROLE, m == 2'h0)
      rd(7'h64, {m, i[0], m == 2'h1 && !d_ext, m, !i[0],
                 m == 2'h1 && !c_ext});
    end
    $display("test line pins done");
    // i2c mode: stored line controls go quiet, multi-pin bits act
    @(posedge I_SYS_CLK);
    I_IFACE_SELECT <= 1'b0;
    wait_n(6);
    `CHK(O_CLOCK_LINE_OE, 1'b0)
    `CHK(O_DATA_LINE_BUS_ROLE, 1'b1)
    rd(7'h64, 8'ha8);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      @(posedge I_SYS_CLK);
      I_MULTI_PIN_THREE <= $random(seed);
      acc(7'h65, 1'b1, d);
      wait_n(4);
      `CHK(O_MULTI_PIN_TWO_OE, d[2])
      `CHK(O_MULTI_PIN_TWO_OUT, d[2] & d[1])
      `CHK(O_AUDIO_SERIAL_IN_SEL, d[4])
      rd(7'h65, {2'h2, d[5:4], d[5] & I_MULTI_PIN_THREE, d[2:0]});
    end
    // back to spi: multi-pin bits stay stored, pin two and serial bits act no more, codec clock bit still acts
    @(posedge I_SYS_CLK);
    I_IFACE_SELECT <= 1'b1;
    wait_n(6);
    `CHK(O_MULTI_PIN_TWO_OE, 1'b0)
    `CHK(O_AUDIO_SERIAL_IN_SEL, 1'b0)
    `CHK(O_CODEC_CORE_CLOCK_SEL, d[0])
    `CHK(O_CLOCK_LINE_OE, 1'b1)
    rd(7'h65, {2'h0, d[5:4], 1'b0, d[2:0]});
    $display("test mode switch done");
    // unmapped place: write dropped, read gives zero
    acc(7'h67, 1'b1, 8'hff);
    rd(7'h67, 8'h00);
    wait_n(3);
    `CHK(O_PLL_N, 5'h0f)
    `CHK(O_REG_HIT, 1'b0)
    $display("test unmapped done");
    wrap_up();
  end
endmodule
